/* File: design/arc_pkg.sv */
// Shared constants for the converter range and channel-mode control block.
package arc_pkg;

  // Channels per converter group.
  localparam int NCH = 8;

  // Register offsets of the host register port.
  localparam logic [3:0] ADR_STATUS   = 4'h1;
  localparam logic [3:0] ADR_SEQ      = 4'h2;
  localparam logic [3:0] ADR_CHAN     = 4'h3;
  localparam logic [3:0] ADR_RNG_A_LO = 4'h4;
  localparam logic [3:0] ADR_RNG_A_HI = 4'h5;
  localparam logic [3:0] ADR_RNG_B_LO = 4'h6;
  localparam logic [3:0] ADR_RNG_B_HI = 4'h7;
  localparam logic [3:0] ADR_OVR_A1   = 4'h8;
  localparam logic [3:0] ADR_OVR_B1   = 4'h9;
  localparam logic [3:0] ADR_OVR_A2   = 4'hA;
  localparam logic [3:0] ADR_OVR_B2   = 4'hB;

  // Field positions inside the sequencer and channel registers.
  localparam int SEQ_EN  = 0;
  localparam int SEQ_LHI = 3;
  localparam int SEQ_LLO = 1;
  localparam int CHA_HI  = 3;
  localparam int CHA_LO  = 0;
  localparam int CHB_HI  = 7;
  localparam int CHB_LO  = 4;

  // Range codes; the pin codes and the register codes share them.
  localparam logic [1:0] RSEL_SOFT = 2'h0;
  localparam logic [1:0] RNG_2V5   = 2'h1;
  localparam logic [1:0] RNG_5V    = 2'h2;
  localparam logic [1:0] RNG_10V   = 2'h3;

  // Multiplexer codes 8 and 9, just above the eight inputs, are diagnostic channels.
  localparam logic [3:0] CH_DIAG_SUPPLY = 4'h8;
  localparam logic [3:0] CH_DIAG_LDO    = 4'h9;

  // Start-up counter: pins are through the synchroniser at INIT_LOAD.
  localparam logic [1:0] INIT_LOAD = 2'h2;
  localparam logic [1:0] INIT_DONE = 2'h3;

  // Reset values.
  localparam logic [7:0] RST_CHAN = 8'h00;
  localparam logic [3:0] RST_SEQ  = 4'h0;
  localparam logic [7:0] RST_RNG  = 8'hFF;
  localparam logic [7:0] RST_OVR  = 8'h00;

endpackage

/* File: design/arc_sync.sv */
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module arc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,  // System clock.
  input  wire logic         arst_n_in,   // Asynchronous reset, active low.
  input  wire logic [W-1:0] async_in,    // Raw pin levels.
  output logic      [W-1:0] sync_out     // Levels safe to use.
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } arc_sync_t;

  arc_sync_t state_ff;
  arc_sync_t nxt_state;

  // The first stage feeds only the second, so metastability stays inside.
  always_comb begin
    nxt_state.meta   = async_in;
    nxt_state.stable = state_ff.meta;
  end

  // Both stages clear to low under reset.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stable;

endmodule // arc_sync

/* File: design/arc_seq.sv */
// Channel sequencer that steps a pair index once per conversion.
`timescale 1ns/1ps
module arc_seq (
  input  wire logic       sys_clk_in,  // System clock.
  input  wire logic       arst_n_in,   // Asynchronous reset, active low.
  input  wire logic       enable_in,   // Sequencer running.
  input  wire logic       step_in,     // One-cycle conversion start.
  input  wire logic [2:0] last_in,     // Last index of the list.
  output logic      [2:0] index_out    // Index for the next step.
);

  typedef struct packed {
    logic [2:0] idx;
  } arc_seq_t;

  arc_seq_t state_ff;
  arc_seq_t nxt_state;

  // Disabling parks the list at its head so a restart is predictable.
  always_comb begin
    nxt_state = state_ff;
    if (!enable_in) begin
      nxt_state.idx = '0;
    end else if (step_in) begin
      if (state_ff.idx >= last_in) begin
        nxt_state.idx = '0;
      end else begin
        nxt_state.idx = state_ff.idx + 3'h1;
      end
    end
  end

  // The index register.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign index_out = state_ff.idx;

endmodule // arc_seq

/* File: design/arc_ctrl.sv */
// Range, overrange and channel-pair control for a dual sampling converter.
`timescale 1ns/1ps
module arc_ctrl (
  input  wire logic        sys_clk_in,           // 10 MHz clock.
  input  wire logic        arst_n_in,            // Async reset, active low.
  input  wire logic [1:0]  range_select_pins_in, // Range select pins.
  input  wire logic [2:0]  channel_pair_pins_in, // Channel pair pins.
  input  wire logic        conv_start_pin_in,    // Conversion start pin.
  input  wire logic        reg_wr_in,            // Register write strobe.
  input  wire logic [3:0]  reg_addr_in,          // Register offset.
  input  wire logic [7:0]  reg_wdata_in,         // Register write data.
  output logic             hw_mode_out,          // Pin operation active.
  output logic      [3:0]  mux_a_sel_out,        // Group A mux code.
  output logic      [3:0]  mux_b_sel_out,        // Group B mux code.
  output logic      [15:0] range_a_out,          // Group A range codes.
  output logic      [15:0] range_b_out,          // Group B range codes.
  output logic      [7:0]  overrange_a_out,      // Group A overrange.
  output logic      [7:0]  overrange_b_out,      // Group B overrange.
  output logic      [7:0]  reg_rdata_out         // Register read data.
);

  typedef struct packed {
    logic [1:0]  init;
    logic        conv_prev, hw;
    logic [7:0]  chan;
    logic [3:0]  seq;
    logic [7:0]  rng_a_lo, rng_a_hi, rng_b_lo, rng_b_hi;
    logic [7:0]  ovr_a1, ovr_b1, ovr_a2, ovr_b2;
    logic [3:0]  sel_a, sel_b;
    logic [15:0] out_rng_a, out_rng_b;
    logic [7:0]  out_ovr_a, out_ovr_b, rdata;
  } arc_ctrl_t;

  arc_ctrl_t   state_ff;
  arc_ctrl_t   nxt_state;

  logic [5:0]  pins_sync;
  logic [1:0]  pin_rsel;
  logic [2:0]  pin_ch, seq_last, seq_idx;
  logic        pin_conv, hw_now, conv_rise, init_done, seq_en, seq_step;
  logic [3:0]  pin_pair, seq_pair, chan_a, chan_b;
  logic [15:0] soft_rng_a, soft_rng_b;
  logic [7:0]  ovr_a_and, ovr_b_and;

  // Register code zero is not a range, so it falls back to the widest one.
  function automatic logic [1:0] soft_code(input logic [1:0] code);
    return (code == arc_pkg::RSEL_SOFT) ? arc_pkg::RNG_10V : code;
  endfunction

  // Expands a group's range registers into one code per channel.
  function automatic logic [15:0] soft_ranges(input logic [15:0] regs);
    logic [15:0] res;
    res = '0;
    for (int i = 0; i < arc_pkg::NCH; i++) begin
      res[2*i +: 2] = soft_code(regs[2*i +: 2]);
    end
    return res;
  endfunction

  // A mux code is legal up to the last diagnostic channel.
  function automatic logic chan_ok(input logic [3:0] code);
    return code <= arc_pkg::CH_DIAG_LDO;
  endfunction

  // All pins cross into the clock domain before any logic reads them.
  arc_sync #(.W (6)) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .async_in   ({conv_start_pin_in, channel_pair_pins_in,
                  range_select_pins_in}),
    .sync_out   (pins_sync)
  );

  assign pin_rsel = pins_sync[1:0];
  assign pin_ch   = pins_sync[4:2];
  assign pin_conv = pins_sync[5];

  // Any non-zero range pin code means pin operation.
  assign hw_now    = pin_rsel != arc_pkg::RSEL_SOFT;
  assign conv_rise = pin_conv & ~state_ff.conv_prev;
  assign init_done = state_ff.init == arc_pkg::INIT_DONE;

  // The sequencer only runs in register operation.
  assign seq_en   = state_ff.seq[arc_pkg::SEQ_EN] & ~hw_now;
  assign seq_last = state_ff.seq[arc_pkg::SEQ_LHI:arc_pkg::SEQ_LLO];
  assign seq_step = seq_en & conv_rise & init_done;

  arc_seq u_seq (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .enable_in  (seq_en),
    .step_in    (seq_step),
    .last_in    (seq_last),
    .index_out  (seq_idx)
  );

  // Pin codes reach inputs 0 to 7 only, so no diagnostic code can appear.
  assign pin_pair = {1'b0, pin_ch};
  assign seq_pair = {1'b0, seq_idx};
  assign chan_a   = state_ff.chan[arc_pkg::CHA_HI:arc_pkg::CHA_LO];
  assign chan_b   = state_ff.chan[arc_pkg::CHB_HI:arc_pkg::CHB_LO];

  // Per-channel register ranges and the agreed overrange masks.
  assign soft_rng_a = soft_ranges({state_ff.rng_a_hi, state_ff.rng_a_lo});
  assign soft_rng_b = soft_ranges({state_ff.rng_b_hi, state_ff.rng_b_lo});
  assign ovr_a_and  = state_ff.ovr_a1 & state_ff.ovr_a2;
  assign ovr_b_and  = state_ff.ovr_b1 & state_ff.ovr_b2;

  // Next state of the whole block.
  always_comb begin
    nxt_state           = state_ff;
    nxt_state.conv_prev = pin_conv;
    nxt_state.hw        = hw_now;
    if (!init_done) begin
      nxt_state.init = state_ff.init + 2'h1;
    end

    // Writes are stored in either mode; pin operation just ignores them.
    if (reg_wr_in) begin
      case (reg_addr_in)
        arc_pkg::ADR_SEQ: begin
          nxt_state.seq = reg_wdata_in[arc_pkg::SEQ_LHI:arc_pkg::SEQ_EN];
        end
        arc_pkg::ADR_CHAN: begin
          // A pair with an unknown code is dropped whole, not half applied.
          if (chan_ok(reg_wdata_in[arc_pkg::CHA_HI:arc_pkg::CHA_LO]) &&
              chan_ok(reg_wdata_in[arc_pkg::CHB_HI:arc_pkg::CHB_LO])) begin
            nxt_state.chan = reg_wdata_in;
          end
        end
        arc_pkg::ADR_RNG_A_LO: nxt_state.rng_a_lo = reg_wdata_in;
        arc_pkg::ADR_RNG_A_HI: nxt_state.rng_a_hi = reg_wdata_in;
        arc_pkg::ADR_RNG_B_LO: nxt_state.rng_b_lo = reg_wdata_in;
        arc_pkg::ADR_RNG_B_HI: nxt_state.rng_b_hi = reg_wdata_in;
        arc_pkg::ADR_OVR_A1:   nxt_state.ovr_a1   = reg_wdata_in;
        arc_pkg::ADR_OVR_A2:   nxt_state.ovr_a2   = reg_wdata_in;
        arc_pkg::ADR_OVR_B1:   nxt_state.ovr_b1   = reg_wdata_in;
        arc_pkg::ADR_OVR_B2:   nxt_state.ovr_b2   = reg_wdata_in;
        default: ;
      endcase
    end

    // Pair loads at start-up, then moves at once on each start edge.
    if (state_ff.init == arc_pkg::INIT_LOAD) begin
      if (hw_now) begin
        nxt_state.sel_a = pin_pair;
        nxt_state.sel_b = pin_pair;
      end else begin
        nxt_state.sel_a = chan_a;
        nxt_state.sel_b = chan_b;
      end
    end else if (conv_rise && init_done) begin
      if (hw_now) begin
        nxt_state.sel_a = pin_pair;
        nxt_state.sel_b = pin_pair;
      end else if (seq_en) begin
        nxt_state.sel_a = seq_pair;
        nxt_state.sel_b = seq_pair;
      end else begin
        nxt_state.sel_a = chan_a;
        nxt_state.sel_b = chan_b;
      end
    end else if (hw_now && (state_ff.sel_a >= arc_pkg::CH_DIAG_SUPPLY ||
                            state_ff.sel_b >= arc_pkg::CH_DIAG_SUPPLY)) begin
      // Leaving a diagnostic pair behind when pins take over is not allowed.
      nxt_state.sel_a = pin_pair;
      nxt_state.sel_b = pin_pair;
    end

    // Applied ranges follow the pins one cycle after the synchroniser delay.
    if (hw_now) begin
      nxt_state.out_rng_a = {arc_pkg::NCH{pin_rsel}};
      nxt_state.out_rng_b = {arc_pkg::NCH{pin_rsel}};
      nxt_state.out_ovr_a = '0;
      nxt_state.out_ovr_b = '0;
    end else begin
      nxt_state.out_rng_a = soft_rng_a;
      nxt_state.out_rng_b = soft_rng_b;
      nxt_state.out_ovr_a = ovr_a_and;
      nxt_state.out_ovr_b = ovr_b_and;
    end

    // Read data follows the address one cycle later.
    case (reg_addr_in)
      arc_pkg::ADR_STATUS:   nxt_state.rdata = {2'h0, seq_idx, hw_now,
                                                 pin_rsel};
      arc_pkg::ADR_SEQ:      nxt_state.rdata = {4'h0, state_ff.seq};
      arc_pkg::ADR_CHAN:     nxt_state.rdata = state_ff.chan;
      arc_pkg::ADR_RNG_A_LO: nxt_state.rdata = state_ff.rng_a_lo;
      arc_pkg::ADR_RNG_A_HI: nxt_state.rdata = state_ff.rng_a_hi;
      arc_pkg::ADR_RNG_B_LO: nxt_state.rdata = state_ff.rng_b_lo;
      arc_pkg::ADR_RNG_B_HI: nxt_state.rdata = state_ff.rng_b_hi;
      arc_pkg::ADR_OVR_A1:   nxt_state.rdata = state_ff.ovr_a1;
      arc_pkg::ADR_OVR_B1:   nxt_state.rdata = state_ff.ovr_b1;
      arc_pkg::ADR_OVR_A2:   nxt_state.rdata = state_ff.ovr_a2;
      arc_pkg::ADR_OVR_B2:   nxt_state.rdata = state_ff.ovr_b2;
      default:               nxt_state.rdata = 8'h00;
    endcase
  end

  // All state with its reset values.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff          <= '0;
      state_ff.chan     <= arc_pkg::RST_CHAN;
      state_ff.seq      <= arc_pkg::RST_SEQ;
      state_ff.rng_a_lo <= arc_pkg::RST_RNG;
      state_ff.rng_a_hi <= arc_pkg::RST_RNG;
      state_ff.rng_b_lo <= arc_pkg::RST_RNG;
      state_ff.rng_b_hi <= arc_pkg::RST_RNG;
      state_ff.ovr_a1   <= arc_pkg::RST_OVR;
      state_ff.ovr_b1   <= arc_pkg::RST_OVR;
      state_ff.ovr_a2   <= arc_pkg::RST_OVR;
      state_ff.ovr_b2   <= arc_pkg::RST_OVR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Every output is a field of the state register.
  assign hw_mode_out     = state_ff.hw;
  assign mux_a_sel_out   = state_ff.sel_a;
  assign mux_b_sel_out   = state_ff.sel_b;
  assign range_a_out     = state_ff.out_rng_a;
  assign range_b_out     = state_ff.out_rng_b;
  assign overrange_a_out = state_ff.out_ovr_a;
  assign overrange_b_out = state_ff.out_ovr_b;
  assign reg_rdata_out   = state_ff.rdata;

  // Checks on mode, pairing, range and register behaviour.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_mode;
    1'b1 |=> hw_mode_out == ($past(pin_rsel) != arc_pkg::RSEL_SOFT);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode does not follow range pins");
  property p_hw_range;
    hw_now |=> range_a_out == {arc_pkg::NCH{$past(pin_rsel)}} &&
               range_b_out == {arc_pkg::NCH{$past(pin_rsel)}};
  endproperty
  a_hw_range: assert property (p_hw_range)
    else $error("pin range not applied to all channels");
  property p_hw_pair;
    hw_now && conv_rise && init_done |=>
      mux_a_sel_out == {1'b0, $past(pin_ch)} &&
      mux_b_sel_out == mux_a_sel_out;
  endproperty
  a_hw_pair: assert property (p_hw_pair)
    else $error("pin pair not taken at conversion start");
  property p_no_diag;
    hw_mode_out |-> mux_a_sel_out < arc_pkg::CH_DIAG_SUPPLY &&
                    mux_b_sel_out < arc_pkg::CH_DIAG_SUPPLY;
  endproperty
  a_no_diag: assert property (p_no_diag)
    else $error("diagnostic channel in pin operation");
  property p_sel_legal;
    chan_ok(mux_a_sel_out) && chan_ok(mux_b_sel_out);
  endproperty
  a_sel_legal: assert property (p_sel_legal)
    else $error("illegal multiplexer code");
  property p_init;
    state_ff.init == arc_pkg::INIT_LOAD && hw_now |=>
      mux_a_sel_out == {1'b0, $past(pin_ch)};
  endproperty
  a_init: assert property (p_init)
    else $error("start-up pair not loaded from pins");
  property p_soft_pair;
    !hw_now && !seq_en && conv_rise && init_done |=>
      mux_a_sel_out == $past(chan_a) && mux_b_sel_out == $past(chan_b);
  endproperty
  a_soft_pair: assert property (p_soft_pair)
    else $error("register pair not applied");
  property p_seq;
    seq_step |=> mux_a_sel_out == {1'b0, $past(seq_idx)} &&
                 mux_b_sel_out == mux_a_sel_out &&
                 seq_idx == (($past(seq_idx) >= $past(seq_last)) ?
                             3'h0 : $past(seq_idx) + 3'h1);
  endproperty
  a_seq: assert property (p_seq)
    else $error("sequencer did not step");
  property p_soft_rng;
    !hw_now |=> range_a_out == $past(soft_rng_a) &&
                range_b_out == $past(soft_rng_b);
  endproperty
  a_soft_rng: assert property (p_soft_rng)
    else $error("register ranges not applied");
  property p_ovr;
    !hw_now |=> overrange_a_out == $past(ovr_a_and) &&
                overrange_b_out == $past(ovr_b_and);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrange mask not applied");
  property p_ovr_hw;
    hw_now |=> overrange_a_out == 8'h00 && overrange_b_out == 8'h00;
  endproperty
  a_ovr_hw: assert property (p_ovr_hw)
    else $error("overrange active in pin operation");
  property p_write;
    reg_wr_in && reg_addr_in == arc_pkg::ADR_OVR_A1 ##1
      !reg_wr_in && reg_addr_in == arc_pkg::ADR_OVR_A1 |=>
      reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_write: assert property (p_write)
    else $error("written value not read back");
  c_hw_conv: cover property (hw_now && conv_rise && init_done);
  c_diag:    cover property (mux_a_sel_out == arc_pkg::CH_DIAG_SUPPLY);
  c_wrap:    cover property (seq_step && seq_idx == seq_last);
  c_ovr:     cover property (overrange_b_out != 8'h00);

endmodule // arc_ctrl

/* File: dv/arc_host_model.sv */
// Host model that drives the configuration pins and the register port.
`timescale 1ns/1ps
module arc_host_model (
  input  wire logic       sys_clk_in,     // System clock.
  input  wire logic [7:0] rdata_in,       // Register read data.
  output logic      [1:0] range_pins_out, // Range select pins.
  output logic      [2:0] pair_pins_out,  // Channel pair pins.
  output logic            start_out,      // Conversion start pin.
  output logic            wr_out,         // Register write strobe.
  output logic      [3:0] addr_out,       // Register offset.
  output logic      [7:0] wdata_out       // Register write data.
);
  // Idle levels at time zero; the pins start in register operation.
  initial begin
    range_pins_out = 2'h0;
    pair_pins_out  = 3'h0;
    start_out      = 1'b0;
    wr_out         = 1'b0;
    addr_out       = 4'h0;
    wdata_out      = 8'h00;
  end

  // One-cycle write; the data is inverted once the strobe drops, so a
  // stale value can never pass for a fresh one.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    wr_out    <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge sys_clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
  endtask

  // The same mask goes to both copies of an overrange pair.
  task automatic wr_ovr(input logic b, input logic [7:0] m);
    wr({3'h4, b}, m);
    wr({3'h5, b}, m);
  endtask

  // Read data is registered, so it is taken two edges after the address.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr_out <= a;
    repeat (2) @(posedge sys_clk_in);
    #1;
    d = rdata_in;
  endtask

  // Both pin groups change together at one edge.
  task automatic set_pins(input logic [1:0] r, input logic [2:0] p);
    @(posedge sys_clk_in);
    range_pins_out <= r;
    pair_pins_out  <= p;
  endtask

  // Start pulse; the low time afterwards exceeds the two-cycle minimum.
  // It returns just past an edge, so callers read settled outputs.
  task automatic start();
    @(posedge sys_clk_in);
    start_out <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    start_out <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1;
  endtask
endmodule // arc_host_model

/* File: dv/arc_ctrl_tb.sv */
// Self-checking testbench for the range and channel-pair control block.
`timescale 1ns/1ps
module arc_ctrl_tb;
  logic        sys_clk_in;
  logic        arst_n_in;
  logic [1:0]  rpins;
  logic [2:0]  ppins;
  logic        cstart;
  logic        wr;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        hw_mode;
  logic [3:0]  mux_a;
  logic [3:0]  mux_b;
  logic [15:0] rng_a;
  logic [15:0] rng_b;
  logic [7:0]  ovr_a;
  logic [7:0]  ovr_b;
  logic [7:0]  rdata;
  logic [7:0]  rd_val;
  logic [1:0]  rc;
  int          failures;
  int          num_checks;
  int          cycles;

  // The model owns every input except the clock and reset.
  arc_host_model host (.sys_clk_in(sys_clk_in), .rdata_in(rdata),
    .range_pins_out(rpins), .pair_pins_out(ppins), .start_out(cstart),
    .wr_out(wr), .addr_out(addr), .wdata_out(wdata));

  arc_ctrl DUT (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .range_select_pins_in(rpins), .channel_pair_pins_in(ppins),
    .conv_start_pin_in(cstart), .reg_wr_in(wr), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .hw_mode_out(hw_mode), .mux_a_sel_out(mux_a),
    .mux_b_sel_out(mux_b), .range_a_out(rng_a), .range_b_out(rng_b),
    .overrange_a_out(ovr_a), .overrange_b_out(ovr_b),
    .reg_rdata_out(rdata));

  // Clock at 10 MHz.
  initial sys_clk_in = 1'b0;
  always #50 sys_clk_in = ~sys_clk_in;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
               exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reset is held ten cycles; five more let the pins pass the synchroniser.
  task automatic do_reset();
    @(posedge sys_clk_in);
    arst_n_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    #1;
  endtask

  // Writes the channel register, starts a conversion, checks the pair.
  task automatic pair_case(input logic [7:0] c, input logic [3:0] ea,
                           input logic [3:0] eb);
    host.wr(arc_pkg::ADR_CHAN, c);
    host.start();
    check(16'(mux_a), 16'(ea));
    check(16'(mux_b), 16'(eb));
  endtask

  // A hang is cut short well above the length of the whole sequence.
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    arst_n_in = 1'b0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    do_reset();
    check(16'(hw_mode), 16'h0000);
    check(rng_a, 16'hFFFF);
    check(rng_b, 16'hFFFF);
    host.rd(arc_pkg::ADR_OVR_A1, rd_val);
    check(16'(rd_val), 16'h0000);
    host.rd(4'hF, rd_val);
    check(16'(rd_val), 16'h0000);
    $display("test reset_values done");

    // A single written copy must not enable anything.
    host.wr(arc_pkg::ADR_OVR_A1, 8'h5A);
    repeat (3) @(posedge sys_clk_in);
    #1;
    check(16'(ovr_a), 16'h0000);
    host.wr(arc_pkg::ADR_OVR_A2, 8'h5A);
    host.wr_ovr(1'b1, 8'hC3);
    repeat (3) @(posedge sys_clk_in);
    #1;
    check(16'(ovr_a), 16'h005A);
    check(16'(ovr_b), 16'h00C3);
    host.rd(arc_pkg::ADR_OVR_B2, rd_val);
    check(16'(rd_val), 16'h00C3);
    $display("test overrange done");

    // Code zero in a range register reads as the widest range.
    host.wr(arc_pkg::ADR_RNG_A_LO, 8'h1B);
    host.wr(arc_pkg::ADR_RNG_B_HI, 8'h65);
    repeat (3) @(posedge sys_clk_in);
    #1;
    check(rng_a, 16'hFFDB);
    check(rng_b, 16'h65FF);
    $display("test channel_range done");

    pair_case(8'h83, 4'h3, 4'h8);
    pair_case(8'h97, 4'h7, 4'h9);
    pair_case(8'hA1, 4'h7, 4'h9);
    $display("test soft_pairing done");

    // Sequencer over indices 0 to 2, wrapping after the last.
    host.wr(arc_pkg::ADR_SEQ, 8'h05);
    for (int i = 0; i < 4; i++) begin
      host.start();
      check(16'(mux_a), 16'(i % 3));
      check(16'(mux_b), 16'(i % 3));
    end
    host.wr(arc_pkg::ADR_SEQ, 8'h00);
    $display("test sequencer done");

    // Pin ranges override registers; the diagnostic pair is purged.
    pair_case(8'h98, 4'h8, 4'h9);
    for (int r = 1; r < 4; r++) begin
      rc = 2'(r);
      host.set_pins(rc, 3'h0);
      repeat (4) @(posedge sys_clk_in);
      #1;
      check(16'(hw_mode), 16'h0001);
      check(rng_a, {8{rc}});
      check(rng_b, {8{rc}});
      check(16'(ovr_a), 16'h0000);
      check(16'(mux_a), 16'h0000);
      check(16'(mux_b), 16'h0000);
    end
    $display("test pin_range done");

    for (int n = 0; n < 8; n++) begin
      host.set_pins(2'h3, 3'(n));
      host.start();
      check(16'(mux_a), 16'(n));
      check(16'(mux_b), 16'(n));
    end
    host.set_pins(2'h0, 3'h0);
    repeat (4) @(posedge sys_clk_in);
    #1;
    check(rng_a, 16'hFFDB);
    check(16'(ovr_a), 16'h005A);
    $display("test pin_pairing done");

    // The pair pins are loaded at reset release without any start.
    host.set_pins(2'h3, 3'h6);
    do_reset();
    check(16'(mux_a), 16'h0006);
    check(16'(mux_b), 16'h0006);
    $display("test reset_load done");
    complete_run();
  end
endmodule // arc_ctrl_tb
